/* design/vpwc_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
module vpwc_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } vpwc_fifo_st_t;

  vpwc_fifo_st_t st_r;
  vpwc_fifo_st_t st_nxt;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic push;
  logic pop;

  assign in_ready_o = (st_r.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (st_r.cnt != '0);
  assign out_data_o = mem_r[st_r.rp];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.wp = (st_r.wp == AW'(DEPTH - 1)) ? '0 : st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = (st_r.rp == AW'(DEPTH - 1)) ? '0 : st_r.rp + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
    if (push) begin
      mem_r[st_r.wp] <= in_data_i;
    end
  end
endmodule

/* design/vpwc_host.sv */
// Host controller: encodes and decodes variable pulse width symbols for the transceiver
module vpwc_host
  import vpwc_pkg::*;
#(
  parameter int unsigned WIDTH = DATA_W,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input wire logic clock_i,
  input wire logic srst_i,
  // User transmit byte stream
  input wire logic [WIDTH-1:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire logic tx_last_i,
  // User receive byte stream
  output logic [WIDTH-1:0] rx_data_o,
  output logic rx_valid_o,
  output logic rx_eof_o,
  output logic arb_lost_o,
  input wire logic loopback_i,
  input wire logic fast_i,
  input wire logic sleep_req_i,
  // Transceiver pins
  output logic tx_pin_o,
  input wire logic rx_pin_i,
  output logic tx_enable_o,
  output logic shaping_loopback_select_o,
  output logic shaping_loopback_select_oe_o,
  output logic busy_o
);

  localparam logic [US_W-1:0] T_THR = US_W'(BIT_THRESH_US);
  localparam logic [US_W-1:0] T_SHORT = US_W'(SHORT_US);
  localparam logic [US_W-1:0] T_LONG = US_W'(LONG_US);
  localparam logic [US_W-1:0] T_SOF = US_W'(SOF_US);
  localparam logic [US_W-1:0] T_EOD = US_W'(EOD_US);
  localparam logic [US_W-1:0] T_SOFMIN = US_W'(SYM_LONG_MIN_US);
  localparam logic [US_W-1:0] T_IDLE = US_W'(IDLE_MIN_US);
  localparam logic [US_W-1:0] T_IDLEMAX = US_W'(IDLE_MAX_US);
  localparam logic [5:0] DIV_LAST = 6'(TICK_DIV - 1);

  // Bit value to symbol length: zero is short when low, long when high
  function automatic logic [US_W-1:0] sym_len(input logic lvl, input logic b);
    sym_len = ((lvl == 1'b1) ^ (b == 1'b0)) ? T_SHORT : T_LONG;
  endfunction

  // Decoded bit from level held and elapsed time
  function automatic logic sym_bit(input logic lvl, input logic [US_W-1:0] t);
    sym_bit = (t < T_THR) ? lvl : ~lvl;
  endfunction

  typedef struct packed {
    logic [5:0] div;
    logic [1:0] rx_sync;
    logic rx_prev;
    logic [US_W-1:0] rx_t;
    logic rx_inframe;
    logic [2:0] rx_nb;
    logic [WIDTH-1:0] rx_sh;
    logic [WIDTH-1:0] rx_data;
    logic rx_valid;
    logic rx_eof;
    vpwc_tx_t txs;
    logic [US_W-1:0] tx_t;
    logic tx_lvl;
    logic [2:0] tx_nb;
    logic [WIDTH-1:0] tx_sh;
    logic tx_last;
    logic tx_en;
    logic lost;
  } vpwc_st_t;

  vpwc_st_t st_r;
  vpwc_st_t st_nxt;
  logic [WIDTH-1:0] f_data;
  logic f_valid;
  logic f_ready;
  logic f_last;
  logic tick;
  logic rx_edge;
  logic idle_ok;
  logic arb_hit;
  logic refill;

  vpwc_fifo #(
    .WIDTH(WIDTH + 1),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .in_data_i({tx_last_i, tx_data_i}),
    .in_valid_i(tx_valid_i),
    .in_ready_o(tx_ready_o),
    .out_data_o({f_last, f_data}),
    .out_valid_o(f_valid),
    .out_ready_i(f_ready)
  );

  assign tick = (st_r.div == DIV_LAST);
  assign rx_edge = (st_r.rx_sync[1] != st_r.rx_prev);
  // Idle window counts from the last edge; between min and max we may start
  // Strictly above the minimum: the free-running tick may land just after the edge
  assign idle_ok = !st_r.rx_sync[1] && st_r.rx_t > T_IDLE; // [RULE8]
  // Bus high while we hold it low means a dominant node; slack covers the echo delay
  assign arb_hit = !loopback_i && (st_r.txs == VPWC_DATA) && !st_r.tx_lvl && st_r.rx_sync[1]
      && (st_r.tx_t < T_SHORT - US_W'(4)); // [RULE9]
  // Next byte taken at the byte boundary so the message runs on without a gap
  assign refill = (st_r.txs == VPWC_DATA) && !arb_hit && (st_r.tx_t == '0) && (st_r.tx_nb == 3'h0)
      && !st_r.tx_last && f_valid;
  assign f_ready = ((st_r.txs == VPWC_IDLE) && idle_ok && st_r.tx_en && !st_r.rx_inframe) || refill;

  always_comb begin
    st_nxt = st_r;
    st_nxt.div = tick ? '0 : st_r.div + 6'h01;
    st_nxt.rx_sync = {st_r.rx_sync[0], rx_pin_i};
    st_nxt.rx_prev = st_r.rx_sync[1];
    st_nxt.rx_valid = 1'b0;
    st_nxt.rx_eof = 1'b0;
    // ----------------------------------------------------------------
    // Receive decoder
    // ----------------------------------------------------------------
    if (rx_edge) begin
      st_nxt.rx_t = '0; // [RULE4]
      if (!st_r.rx_inframe) begin
        if (!st_r.rx_prev) begin
          st_nxt.rx_nb = '0;
        end
      end else if (st_r.rx_prev && st_r.rx_t >= T_SOFMIN) begin
        st_nxt.rx_nb = '0; // [RULE5]
      end else begin
        st_nxt.rx_sh = {st_r.rx_sh[WIDTH-2:0], sym_bit(st_r.rx_prev, st_r.rx_t)}; // [RULE6]
        st_nxt.rx_nb = st_r.rx_nb + 3'h1;
        if (st_r.rx_nb == 3'h7) begin
          st_nxt.rx_data = {st_r.rx_sh[WIDTH-2:0], sym_bit(st_r.rx_prev, st_r.rx_t)};
          st_nxt.rx_valid = 1'b1;
        end
      end
      // Any rising edge opens the frame, however long the low before it
      if (st_r.rx_prev == 1'b0) begin
        st_nxt.rx_inframe = 1'b1;
      end
    end else if (tick && st_r.rx_t != T_IDLEMAX) begin
      st_nxt.rx_t = st_r.rx_t + 1'b1;
      // Low held to end-of-data closes the frame
      if (st_r.rx_inframe && !st_r.rx_sync[1] && st_r.rx_t + 1'b1 == T_EOD) begin
        st_nxt.rx_inframe = 1'b0; // [RULE7]
        st_nxt.rx_eof = 1'b1;
      end
    end
    // ----------------------------------------------------------------
    // Transmitter wake and encoder
    // ----------------------------------------------------------------
    // Raise enable on bus activity since the device cannot wake itself
    if (rx_edge || (f_valid && !sleep_req_i)) begin
      st_nxt.tx_en = 1'b1; // [RULE14]
    end else if (sleep_req_i && st_r.txs == VPWC_IDLE) begin
      st_nxt.tx_en = 1'b0; // [RULE13]
    end
    if (tick && st_r.tx_t != '0) begin
      st_nxt.tx_t = st_r.tx_t - 1'b1;
    end
    case (st_r.txs)
      VPWC_IDLE: begin
        st_nxt.lost = 1'b0;
        if (f_valid && f_ready) begin
          st_nxt.tx_sh = f_data;
          st_nxt.tx_last = f_last;
          st_nxt.tx_nb = '0;
          st_nxt.tx_lvl = 1'b1; // [RULE11]
          st_nxt.tx_t = T_SOF; // [RULE5]
          st_nxt.txs = VPWC_SOF;
        end
      end
      VPWC_SOF, VPWC_DATA: begin
        if (arb_hit) begin
          st_nxt.tx_lvl = 1'b0; // [RULE9]
          st_nxt.lost = 1'b1;
          st_nxt.txs = VPWC_LOST;
        end else if (st_r.tx_t == '0) begin
          if (st_r.txs == VPWC_DATA && st_r.tx_nb == 3'h0 && st_r.tx_last) begin
            st_nxt.tx_lvl = 1'b0;
            st_nxt.tx_t = T_EOD; // [RULE7]
            st_nxt.txs = VPWC_EOD;
          end else if (st_r.txs == VPWC_DATA && st_r.tx_nb == 3'h0 && !f_valid) begin
            st_nxt.tx_lvl = 1'b0;
            st_nxt.tx_t = T_EOD;
            st_nxt.txs = VPWC_EOD;
          end else if (refill) begin
            st_nxt.tx_lvl = ~st_r.tx_lvl;
            st_nxt.tx_t = sym_len(~st_r.tx_lvl, f_data[WIDTH-1]); // [RULE6]
            st_nxt.tx_sh = {f_data[WIDTH-2:0], 1'b0};
            st_nxt.tx_last = f_last;
            st_nxt.tx_nb = 3'h1;
          end else begin
            st_nxt.tx_lvl = ~st_r.tx_lvl;
            st_nxt.tx_t = sym_len(~st_r.tx_lvl, st_r.tx_sh[WIDTH-1]); // [RULE6]
            st_nxt.tx_sh = {st_r.tx_sh[WIDTH-2:0], 1'b0};
            st_nxt.tx_nb = st_r.tx_nb + 3'h1;
            st_nxt.txs = VPWC_DATA;
          end
        end
      end
      VPWC_EOD: begin
        if (st_r.tx_t == '0) begin
          st_nxt.txs = VPWC_IDLE;
        end
      end
      VPWC_LOST: begin
        // Stay silent until the winner's frame ends
        if (st_nxt.rx_eof) begin
          st_nxt.txs = VPWC_IDLE;
        end
      end
      default: begin
        st_nxt.txs = VPWC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  logic [1:0] mode_r;
  logic pin_tx_r;
  logic busy_r;
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      mode_r <= MODE_NORMAL;
      pin_tx_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      mode_r <= loopback_i ? MODE_LOOP : (fast_i ? MODE_FAST : MODE_NORMAL); // [RULE12]
      pin_tx_r <= st_nxt.tx_lvl && (st_nxt.txs != VPWC_LOST);
      busy_r <= (st_nxt.txs != VPWC_IDLE) || st_nxt.rx_inframe;
    end
  end

  assign tx_pin_o = pin_tx_r;
  assign tx_enable_o = st_r.tx_en;
  assign shaping_loopback_select_o = mode_r[0];
  assign shaping_loopback_select_oe_o = (mode_r != MODE_LOOP);
  assign rx_data_o = st_r.rx_data;
  assign rx_valid_o = st_r.rx_valid;
  assign rx_eof_o = st_r.rx_eof;
  assign arb_lost_o = st_r.lost;
  assign busy_o = busy_r;
endmodule

/* design/vpwc_pkg.sv */
// Package of constants and types for the variable pulse width bus host controller
// Function
// RULE1: Device latches its bus driver off on over-temperature, whatever transmit does.
// RULE2: Only a rising transmit edge may release the latched-off driver.
// RULE3: The release needs the die cooled by the hysteresis margin first.
// RULE4: Decoder restarts its timer at every receive transition and judges elapsed time.
// RULE5: Every frame opens with a 200 us high start-of-frame symbol.
// RULE6: Data symbols shorter than 96 us give one value, longer give the other.
// RULE7: A message closes with a 200 us low end-of-data symbol.
// RULE8: Arbitration for a new message waits for 280 to 320 us bus idle.
// RULE9: Longest run of zero bits wins arbitration; losers stop sending at once.
// RULE10: Over-temperature is a digital fault input; set beats a clearing edge.
// RULE11: Transmit one drives the bus high, transmit zero releases it low.
// RULE12: Loopback routes transmit to receive without touching the bus.
// RULE13: Receiver always on; transmitter enable gates only the transmitter.
// RULE14: Device never self-wakes; host raises transmitter enable on receive activity.
package vpwc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned SOF_US = 200;
  localparam int unsigned EOD_US = 200;
  localparam int unsigned BIT_THRESH_US = 96;
  localparam int unsigned SHORT_US = 64;
  localparam int unsigned LONG_US = 128;
  localparam int unsigned IDLE_MIN_US = 280;
  localparam int unsigned IDLE_MAX_US = 320;
  localparam int unsigned TICK_HZ = 1_000_000;
  // One microsecond tick from the 50 MHz clock
  localparam int unsigned TICK_DIV = CLK_HZ / TICK_HZ;
  localparam int unsigned SYM_LONG_MIN_US = SOF_US - 20;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned US_W = 10;

  // Pin level of the three-state mode select: low, high, released
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_FAST = 2'h1;
  localparam logic [1:0] MODE_LOOP = 2'h2;

  typedef enum logic [2:0] {
    VPWC_IDLE = 3'b000,
    VPWC_SOF = 3'b001,
    VPWC_DATA = 3'b010,
    VPWC_EOD = 3'b011,
    VPWC_LOST = 3'b100
  } vpwc_tx_t;

endpackage

/* testbench/tb_top.sv */
// Top testbench for the host controller with the transceiver model
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0, srst_i = 1'b1, tx_valid_i = 1'b0, tx_last_i = 1'b0, loopback_i = 1'b0;
  logic fast_i = 1'b0, sleep_req_i = 1'b0, other = 1'b0, hot = 1'b0, cooled = 1'b1;
  logic [7:0] tx_data_i = 8'h00, rx_data_o;
  logic tx_ready_o, rx_valid_o, rx_eof_o, arb_lost_o, tx_pin_o, rx_pin, tx_enable_o, sel_o, sel_oe_o, busy_o, bus;
  int num_errors = 0, num_checks = 0, cyc = 0;
  always #10 clock_i = ~clock_i;
  vpwc_host DUT (.clock_i(clock_i), .srst_i(srst_i), .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i),
    .tx_ready_o(tx_ready_o), .tx_last_i(tx_last_i), .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o),
    .rx_eof_o(rx_eof_o), .arb_lost_o(arb_lost_o), .loopback_i(loopback_i), .fast_i(fast_i),
    .sleep_req_i(sleep_req_i), .tx_pin_o(tx_pin_o), .rx_pin_i(rx_pin), .tx_enable_o(tx_enable_o),
    .shaping_loopback_select_o(sel_o), .shaping_loopback_select_oe_o(sel_oe_o), .busy_o(busy_o));
  vpwc_xcvr_model u_xcvr (.tx_i(tx_pin_o), .enable_i(tx_enable_o), .select_oe_i(sel_oe_o), .hot_i(hot),
    .cooled_i(cooled), .other_i(other), .bus_o(bus), .rx_o(rx_pin));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic do_reset;
    srst_i = 1'b1;
    repeat (5) @(negedge clock_i);
    check("reset pins", {4'h0, tx_pin_o, busy_o, sel_oe_o, rx_valid_o}, 8'h02);
    srst_i = 1'b0;
  endtask
  task automatic push(input logic [7:0] d, input logic last);
    tx_data_i = d;
    tx_last_i = last;
    tx_valid_i = 1'b1;
    while (tx_ready_o !== 1'b1) @(negedge clock_i);
    @(negedge clock_i);
    tx_valid_i = 1'b0;
    // One idle edge between pushes
    @(negedge clock_i);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_pins;
    loopback_i = 1'b1;
    repeat (4) @(negedge clock_i);
    check("loop mode", {7'h00, sel_oe_o}, 8'h00);
    loopback_i = 1'b0;
    fast_i = 1'b1;
    repeat (4) @(negedge clock_i);
    check("fast mode", {6'h00, sel_oe_o, sel_o}, 8'h03);
    fast_i = 1'b0;
    repeat (4) @(negedge clock_i);
    check("normal mode", {6'h00, sel_oe_o, sel_o}, 8'h02);
    $display("test pins done");
  endtask
  task automatic t_fifo;
    sleep_req_i = 1'b1;
    repeat (4) @(negedge clock_i);
    check("asleep enable", {7'h00, tx_enable_o}, 8'h00);
    for (int i = 0; i < 8; i++) push(8'(i), 1'b0);
    check("full ready", {7'h00, tx_ready_o}, 8'h00);
    // Refused push: one cycle of valid while full
    tx_valid_i = 1'b1;
    @(negedge clock_i);
    tx_valid_i = 1'b0;
    do_reset();
    sleep_req_i = 1'b0;
    check("empty ready", {7'h00, tx_ready_o}, 8'h01);
    $display("test fifo done");
  endtask
  task automatic t_frame;
    // Byte with short and long symbols at both levels
    push(8'h95, 1'b1);
    while (tx_pin_o !== 1'b1) @(negedge clock_i);
    check("awake enable", {7'h00, tx_enable_o}, 8'h01);
    while (rx_valid_o !== 1'b1) @(negedge clock_i);
    check("rx byte", rx_data_o, 8'h95);
    while (rx_eof_o !== 1'b1) @(negedge clock_i);
    check("eod level", {7'h00, tx_pin_o}, 8'h00);
    $display("test frame done");
  endtask
  task automatic t_thermal;
    cooled = 1'b0;
    hot = 1'b1;
    @(negedge clock_i);
    hot = 1'b0;
    // All short symbols: low, high, low, high ...
    push(8'h55, 1'b1);
    while (tx_pin_o !== 1'b1) @(negedge clock_i);
    check("hot sof bus", {7'h00, bus}, 8'h00);
    while (tx_pin_o !== 1'b0) @(negedge clock_i);
    while (tx_pin_o !== 1'b1) @(negedge clock_i);
    check("warm edge bus", {7'h00, bus}, 8'h00);
    cooled = 1'b1;
    hot = 1'b1;
    while (tx_pin_o !== 1'b0) @(negedge clock_i);
    while (tx_pin_o !== 1'b1) @(negedge clock_i);
    check("hot edge bus", {7'h00, bus}, 8'h00);
    hot = 1'b0;
    while (tx_pin_o !== 1'b0) @(negedge clock_i);
    while (tx_pin_o !== 1'b1) @(negedge clock_i);
    check("cool edge bus", {7'h00, bus}, 8'h01);
    $display("test thermal done");
  endtask
  task automatic t_arb;
    // Frame of the thermal test runs on; take its next low symbol
    while (tx_pin_o !== 1'b0) @(negedge clock_i);
    // Another node holds the bus high in our low symbol
    other = 1'b1;
    while (arb_lost_o !== 1'b1) @(negedge clock_i);
    repeat (100) @(negedge clock_i);
    check("loser pin", {6'h00, arb_lost_o, tx_pin_o}, 8'h02);
    other = 1'b0;
    $display("test arbitration done");
  endtask
  initial begin
    do_reset();
    t_pins();
    t_fifo();
    t_frame();
    t_thermal();
    t_arb();
    finish_test();
  end
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 125000) begin
      num_errors++;
      finish_test();
    end
  end
endmodule
bind vpwc_host vpwc_host_props u_props (.clock_i(clock_i), .srst_i(srst_i), .tx_pin_o(tx_pin_o), .busy_o(busy_o),
  .rx_valid_o(rx_valid_o), .rx_eof_o(rx_eof_o), .arb_lost_o(arb_lost_o), .tx_enable_o(tx_enable_o),
  .sleep_req_i(sleep_req_i), .loopback_i(loopback_i), .fast_i(fast_i),
  .shaping_loopback_select_o(shaping_loopback_select_o),
  .shaping_loopback_select_oe_o(shaping_loopback_select_oe_o));

/* testbench/vpwc_host_props.sv */
// Checker of the host controller's pin timing and pulses
module vpwc_host_props (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic tx_pin_o,
  input wire logic busy_o,
  input wire logic rx_valid_o,
  input wire logic rx_eof_o,
  input wire logic arb_lost_o,
  input wire logic tx_enable_o,
  input wire logic sleep_req_i,
  input wire logic loopback_i,
  input wire logic fast_i,
  input wire logic shaping_loopback_select_o,
  input wire logic shaping_loopback_select_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev_r;
  logic [15:0] len_r;
  // Cycles the pin held its previous level; saturates on long idle
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      prev_r <= 1'b0;
      len_r <= 16'h0000;
    end else begin
      prev_r <= tx_pin_o;
      len_r <= (tx_pin_o != prev_r) ? 16'h0001 : (len_r == 16'hFFFF) ? len_r : len_r + 16'h0001;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  // One tick of slack, the divider phase is free
  property p_hi_len;
    prev_r && !tx_pin_o |-> len_r inside {[16'h0C4E:16'h0CB2], [16'h18CE:16'h1932], [16'h26DE:16'h2742]};
  endproperty
  property p_lo_len;
    !prev_r && tx_pin_o |-> len_r inside {[16'h0C4E:16'h0CB2], [16'h18CE:16'h1932]} || len_r >= 16'h36B0;
  endproperty
  property p_rise_busy;
    !prev_r && tx_pin_o |-> busy_o;
  endproperty
  property p_rxv_pulse;
    rx_valid_o |=> !rx_valid_o;
  endproperty
  property p_eof_pulse;
    rx_eof_o |=> !rx_eof_o;
  endproperty
  property p_arb;
    arb_lost_o |-> !tx_pin_o;
  endproperty
  property p_loop;
    loopback_i [*3] |-> !shaping_loopback_select_oe_o;
  endproperty
  property p_fast;
    (!loopback_i && fast_i) [*3] |-> shaping_loopback_select_oe_o && shaping_loopback_select_o;
  endproperty
  property p_sleep;
    (sleep_req_i && !busy_o) [*3] |-> !tx_enable_o;
  endproperty
  a_hi_len: assert property (p_hi_len) else $error("tx pin high time wrong");
  a_lo_len: assert property (p_lo_len) else $error("tx pin low time wrong");
  a_rise_busy: assert property (p_rise_busy) else $error("frame without busy");
  a_rxv_pulse: assert property (p_rxv_pulse) else $error("rx valid too long");
  a_eof_pulse: assert property (p_eof_pulse) else $error("rx eof too long");
  a_arb: assert property (p_arb) else $error("loser still sends");
  a_loop: assert property (p_loop) else $error("mode pin not released");
  a_fast: assert property (p_fast) else $error("mode pin not high");
  a_sleep: assert property (p_sleep) else $error("enable high in sleep");
  c_eof: cover property (rx_eof_o);
  c_arb: cover property (arb_lost_o);
  c_loop: cover property (!shaping_loopback_select_oe_o);
endmodule

/* testbench/vpwc_xcvr_model.sv */
// Behavioural model of the bus transceiver facing the host
module vpwc_xcvr_model (
  input wire logic tx_i,
  input wire logic enable_i,
  input wire logic select_oe_i,
  input wire logic hot_i,
  input wire logic cooled_i,
  input wire logic other_i,
  output logic bus_o,
  output logic rx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic off_r = 1'b0;
  // Set wins over a clearing edge
  always @(posedge hot_i or posedge tx_i) begin
    if (hot_i) off_r <= 1'b1;
    else if (cooled_i) off_r <= 1'b0;
  end
  // Pull-down holds the bus low when no node sources it
  assign bus_o = (tx_i && enable_i && select_oe_i && !off_r) || other_i;
  assign rx_o = select_oe_i ? bus_o : tx_i;
endmodule
